// >>> rtl/nsc_check.sv
// nsc_check: opcode decode, identifier classification and list walker
// assumes commands arrive as one-cycle strobes from the queue fetcher
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps

module nsc_check #(
  parameter int unsigned TBL_DEPTH = 16
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         cmdValid,
  input  wire logic [nsc_pkg::OPC_W-1:0]    cmdOpcode,
  input  wire logic [nsc_pkg::NAMESPACE_ID_FIELD_W-1:0]   namespaceIdField,
  input  wire logic [3:0]                   cmdQueueId,
  input  wire logic                         cmdIsIdentify,
  input  wire logic [nsc_pkg::SEL_W-1:0]    identifyStructureSelector,
  input  wire logic [nsc_pkg::NAMESPACE_ID_FIELD_W-1:0]   listStartId,
  input  wire logic                         controllerReadyFlag,
  input  wire logic                         sharedFeatures,
  output logic                              cplValid,
  output logic [nsc_pkg::STAT_W-1:0]        cplStatus,
  output logic [1:0]                        cplDirection,
  output logic                              cplDataAllowed,
  output logic                              cplBroadcast,
  output logic                              cplNsDataZero,
  output logic [4:0]                        cplClass,
  output logic                              listValid,
  output logic [nsc_pkg::NAMESPACE_ID_FIELD_W-1:0]        listId,
  output logic                              listLast,
  input  wire logic [nsc_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [nsc_pkg::DATA_W-1:0]   regWdata,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic [nsc_pkg::DATA_W-1:0]        regRdata
);
  import nsc_pkg::*;

  localparam int unsigned IDX_W = $clog2(TBL_DEPTH);

  if (TBL_DEPTH < 2 || TBL_DEPTH > LIST_MAX) begin : g_depthChk
    $error("TBL_DEPTH out of range");
  end

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [DATA_W-1:0]    nsCount;
    logic [DATA_W-1:0]    allocCap;
    logic [IDX_W-1:0]     tblIdx;
    logic [TBL_DEPTH-1:0] allocated;
    logic [TBL_DEPTH-1:0] attached;
    logic [15:0]          abortCnt;
    logic                 cplValid;
    logic [STAT_W-1:0]    cplStatus;
    logic [1:0]           cplDirection;
    logic                 cplDataAllowed;
    logic                 cplBroadcast;
    logic                 cplNsDataZero;
    logic [4:0]           cplClass;
    nsc_lstate_t          lstate;
    logic                 listActive;
    logic [NAMESPACE_ID_FIELD_W-1:0]    scanId;
    logic [10:0]          listCnt;
    logic                 listValid;
    logic [NAMESPACE_ID_FIELD_W-1:0]    listId;
    logic                 listLast;
    logic [DATA_W-1:0]    rdata;
  } nsc_state_t;

  nsc_state_t st_r;
  nsc_state_t st_nxt;

  // ********************************************************
  // combinational decode
  // ********************************************************
  logic             opDefined;
  logic             opVendor;
  logic             bcastOk;
  logic             idValid;
  logic             idBcast;
  logic             idInTbl;
  logic [IDX_W-1:0] idIdx;
  logic             idAlloc;
  logic             idActive;
  logic [DATA_W-1:0] allocLimit;
  logic [DATA_W-1:0] allocUsed;
  logic             scanHit;
  logic             listReq;
  logic             scanEnd;
  logic [IDX_W-1:0] scanIdx;

  always_comb begin
    case (cmdOpcode)
      OPC_FLUSH, OPC_WRITE, OPC_READ, OPC_WR_UNCOR, OPC_COMPARE, OPC_WR_ZERO,
      OPC_DSET_MGMT, OPC_VERIFY, OPC_RSV_REG, OPC_RSV_RPT, OPC_RSV_ACQ,
      OPC_RSV_REL: opDefined = 1'b1;
      default:     opDefined = 1'b0;
    endcase
  end

  assign opVendor = cmdOpcode[OPC_VENDOR_BIT];
  // outside identify, only flush among the defined opcodes may carry the broadcast identifier
  assign bcastOk  = (cmdOpcode == OPC_FLUSH) && !cmdIsIdentify;
  assign idBcast  = (namespaceIdField == NAMESPACE_ID_FIELD_BROADCAST);
  assign idValid  = (namespaceIdField != NAMESPACE_ID_FIELD_ZERO) && !idBcast
                    && (namespaceIdField <= st_r.nsCount);
  assign idInTbl  = idValid && (namespaceIdField <= NAMESPACE_ID_FIELD_W'(TBL_DEPTH));
  assign idIdx    = IDX_W'(namespaceIdField - 32'd1);
  assign idAlloc  = idInTbl && st_r.allocated[idIdx];
  assign idActive = idAlloc && st_r.attached[idIdx];
  assign allocLimit = (st_r.allocCap == ALLOC_CAP_RST) ? st_r.nsCount
                                                       : st_r.allocCap;
  assign scanIdx  = IDX_W'(st_r.scanId - 32'd1);
  // a wrapped start id would alias the last entry
  assign scanEnd  = (st_r.scanId == NAMESPACE_ID_FIELD_ZERO) || (st_r.scanId > NAMESPACE_ID_FIELD_W'(TBL_DEPTH))
                    || (st_r.scanId > st_r.nsCount);
  assign scanHit  = !scanEnd && st_r.allocated[scanIdx]
                    && (!st_r.listActive || st_r.attached[scanIdx]);
  assign listReq  = cmdValid && controllerReadyFlag && cmdIsIdentify
                    && (identifyStructureSelector == SEL_ACTIVE_LST
                        || identifyStructureSelector == SEL_ALLOC_LST);

  always_comb begin
    allocUsed = '0;
    for (int i = 0; i < TBL_DEPTH; i++) begin
      allocUsed = allocUsed + DATA_W'(st_r.allocated[i]);
    end
  end

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    st_nxt           = st_r;
    st_nxt.cplValid  = 1'b0;
    st_nxt.listValid = 1'b0;
    st_nxt.listLast  = 1'b0;
    st_nxt.rdata     = '0;

    // command check; any queue id accepted alike
    if (cmdValid && controllerReadyFlag) begin
      st_nxt.cplValid       = 1'b1;
      st_nxt.cplDirection   = cmdOpcode[1:0];
      st_nxt.cplBroadcast   = idBcast;
      st_nxt.cplNsDataZero  = 1'b0;
      st_nxt.cplDataAllowed = 1'b0;
      if (idBcast) begin
        st_nxt.cplClass = NSC_CL_BCAST;
      end else if (!idValid) begin
        st_nxt.cplClass = NSC_CL_INVALID;
      end else if (!idAlloc) begin
        st_nxt.cplClass = NSC_CL_UNALLOC;
      end else if (!idActive) begin
        st_nxt.cplClass = NSC_CL_INACTIVE;
      end else begin
        st_nxt.cplClass = NSC_CL_ACTIVE;
      end
      if (cmdIsIdentify) begin
        st_nxt.cplDirection = NSC_DIR_D2H;
        if (identifyStructureSelector == SEL_NS_DATA) begin
          st_nxt.cplStatus      = (idValid || idBcast) ? ST_SUCCESS : ST_INV_NS_FMT;
          st_nxt.cplNsDataZero  = !idActive;
          st_nxt.cplDataAllowed = idValid;
        end else if (identifyStructureSelector == SEL_ACTIVE_LST
                     || identifyStructureSelector == SEL_ALLOC_LST) begin
          st_nxt.cplStatus      = ST_SUCCESS;
          st_nxt.cplDataAllowed = 1'b1;
          st_nxt.lstate         = NSC_LS_SCAN;
          st_nxt.listActive     = (identifyStructureSelector == SEL_ACTIVE_LST);
          st_nxt.scanId         = listStartId + 32'd1;
          st_nxt.listCnt        = '0;
        end else begin
          st_nxt.cplStatus = ST_INV_FIELD;
        end
      end else if (!opDefined && !opVendor) begin
        st_nxt.cplStatus = ST_INV_OPCODE;
      end else if (opVendor) begin
        st_nxt.cplStatus      = ST_SUCCESS;
        st_nxt.cplDataAllowed = (cmdOpcode[1:0] != NSC_DIR_NONE);
      end else if (!idValid && !(idBcast && bcastOk)) begin
        st_nxt.cplStatus = ST_INV_NS_FMT;
      end else if (idValid && !idActive) begin
        st_nxt.cplStatus = ST_INV_FIELD;
      end else begin
        st_nxt.cplStatus      = ST_SUCCESS;
        st_nxt.cplDataAllowed = (cmdOpcode[1:0] != NSC_DIR_NONE);
      end
      if (st_nxt.cplStatus != ST_SUCCESS) begin
        st_nxt.abortCnt = st_r.abortCnt + 16'd1;
      end
    end

    // list walker
    // a new list request restarts the walk, so the running step is skipped
    case (listReq ? NSC_LS_IDLE : st_r.lstate)
      NSC_LS_IDLE: begin
      end
      NSC_LS_SCAN: begin
        if (scanEnd || st_r.listCnt == 11'(LIST_MAX)) begin
          st_nxt.lstate   = NSC_LS_DONE;
        end else begin
          st_nxt.scanId = st_r.scanId + 32'd1;
          if (scanHit) begin
            st_nxt.listValid = 1'b1;
            st_nxt.listId    = st_r.scanId;
            st_nxt.listCnt   = st_r.listCnt + 11'd1;
          end
        end
      end
      NSC_LS_DONE: begin
        st_nxt.listLast = 1'b1;
        st_nxt.lstate   = NSC_LS_IDLE;
      end
      default: st_nxt.lstate = NSC_LS_IDLE;
    endcase

    // register port
    if (regWr) begin
      case (regAddr)
        REG_NS_COUNT:  st_nxt.nsCount  = regWdata;
        REG_ALLOC_CAP: st_nxt.allocCap = regWdata;
        REG_TBL_IDX:   st_nxt.tblIdx   = IDX_W'(regWdata);
        REG_TBL_DATA: begin
          // refuse a new allocation beyond the cap
          if (!regWdata[TBL_ALLOC_BIT] || st_r.allocated[st_r.tblIdx]
              || allocUsed < allocLimit) begin
            st_nxt.allocated[st_r.tblIdx] = regWdata[TBL_ALLOC_BIT];
            st_nxt.attached[st_r.tblIdx]  = regWdata[TBL_ALLOC_BIT]
                                            & regWdata[TBL_ATTACH_BIT];
          end
        end
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        REG_NS_COUNT:  st_nxt.rdata = st_r.nsCount;
        REG_ALLOC_CAP: st_nxt.rdata = st_r.allocCap;
        REG_TBL_IDX:   st_nxt.rdata = DATA_W'(st_r.tblIdx);
        REG_TBL_DATA:  st_nxt.rdata = {30'h0, st_r.attached[st_r.tblIdx],
                                       st_r.allocated[st_r.tblIdx]};
        REG_STATUS:    st_nxt.rdata = {allocUsed[15:0], 12'h0, st_r.lstate,
                                       sharedFeatures};
        REG_ABORTS:    st_nxt.rdata = {16'h0, st_r.abortCnt};
        default:       st_nxt.rdata = '0;
      endcase
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.nsCount  <= NS_COUNT_RST;
      st_r.allocCap <= ALLOC_CAP_RST;
      st_r.lstate   <= NSC_LS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cplValid       = st_r.cplValid;
  assign cplStatus      = st_r.cplStatus;
  assign cplDirection   = st_r.cplDirection;
  assign cplDataAllowed = st_r.cplDataAllowed;
  assign cplBroadcast   = st_r.cplBroadcast;
  assign cplNsDataZero  = st_r.cplNsDataZero;
  assign cplClass       = st_r.cplClass;
  assign listValid      = st_r.listValid;
  assign listId         = st_r.listId;
  assign listLast       = st_r.listLast;
  assign regRdata       = st_r.rdata;

endmodule

// >>> rtl/nsc_pkg.sv
// nsc_pkg: constants and types for the namespace identifier command checker
// assumes a single 10 MHz controller clock domain
package nsc_pkg;

  // ********************************************************
  // widths
  // ********************************************************
  localparam int unsigned NAMESPACE_ID_FIELD_W  = 32;
  localparam int unsigned OPC_W   = 8;
  localparam int unsigned SEL_W   = 8;
  localparam int unsigned STAT_W  = 8;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;

  // ********************************************************
  // identifier values
  // ********************************************************
  localparam logic [NAMESPACE_ID_FIELD_W-1:0] NAMESPACE_ID_FIELD_ZERO      = 32'h0000_0000;
  localparam logic [NAMESPACE_ID_FIELD_W-1:0] NAMESPACE_ID_FIELD_BROADCAST = 32'hFFFF_FFFF;

  // ********************************************************
  // opcodes
  // ********************************************************
  localparam logic [OPC_W-1:0] OPC_FLUSH     = 8'h00;
  localparam logic [OPC_W-1:0] OPC_WRITE     = 8'h01;
  localparam logic [OPC_W-1:0] OPC_READ      = 8'h02;
  localparam logic [OPC_W-1:0] OPC_WR_UNCOR  = 8'h04;
  localparam logic [OPC_W-1:0] OPC_COMPARE   = 8'h05;
  localparam logic [OPC_W-1:0] OPC_WR_ZERO   = 8'h08;
  localparam logic [OPC_W-1:0] OPC_DSET_MGMT = 8'h09;
  localparam logic [OPC_W-1:0] OPC_VERIFY    = 8'h0C;
  localparam logic [OPC_W-1:0] OPC_RSV_REG   = 8'h0D;
  localparam logic [OPC_W-1:0] OPC_RSV_RPT   = 8'h0E;
  localparam logic [OPC_W-1:0] OPC_RSV_ACQ   = 8'h11;
  localparam logic [OPC_W-1:0] OPC_RSV_REL   = 8'h15;
  localparam int unsigned      OPC_VENDOR_BIT = 7;

  // ********************************************************
  // transfer direction field, opcode bits 1:0
  // ********************************************************
  typedef enum logic [1:0] {
    NSC_DIR_NONE = 2'h0,
    NSC_DIR_H2D  = 2'h1,
    NSC_DIR_D2H  = 2'h2,
    NSC_DIR_BIDI = 2'h3
  } nsc_dir_t;

  // ********************************************************
  // identify selectors
  // ********************************************************
  localparam logic [SEL_W-1:0] SEL_NS_DATA    = 8'h00;
  localparam logic [SEL_W-1:0] SEL_ACTIVE_LST = 8'h02;
  localparam logic [SEL_W-1:0] SEL_ALLOC_LST  = 8'h10;
  localparam int unsigned      LIST_MAX       = 1024;

  // ********************************************************
  // completion status codes
  // ********************************************************
  localparam logic [STAT_W-1:0] ST_SUCCESS     = 8'h00;
  localparam logic [STAT_W-1:0] ST_INV_OPCODE  = 8'h01;
  localparam logic [STAT_W-1:0] ST_INV_FIELD   = 8'h02;
  localparam logic [STAT_W-1:0] ST_INV_NS_FMT  = 8'h0B;

  // ********************************************************
  // identifier classes
  // ********************************************************
  typedef enum logic [4:0] {
    NSC_CL_INVALID  = 5'b00001,
    NSC_CL_BCAST    = 5'b00010,
    NSC_CL_UNALLOC  = 5'b00100,
    NSC_CL_INACTIVE = 5'b01000,
    NSC_CL_ACTIVE   = 5'b10000
  } nsc_class_t;

  // ********************************************************
  // register map (word byte addresses)
  // ********************************************************
  localparam logic [ADDR_W-1:0] REG_NS_COUNT  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ALLOC_CAP = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TBL_IDX   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TBL_DATA  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ABORTS    = 8'h14;
  localparam logic [DATA_W-1:0] NS_COUNT_RST  = 32'h0000_0010;
  localparam logic [DATA_W-1:0] ALLOC_CAP_RST = 32'h0000_0000;
  localparam int unsigned       TBL_ALLOC_BIT = 0;
  localparam int unsigned       TBL_ATTACH_BIT = 1;

  // ********************************************************
  // list walker states
  // ********************************************************
  typedef enum logic [2:0] {
    NSC_LS_IDLE = 3'b001,
    NSC_LS_SCAN = 3'b010,
    NSC_LS_DONE = 3'b100
  } nsc_lstate_t;

endpackage

// >>> tb/nsc_check_asserts.sv
// nsc_check_asserts: port-level checker for nsc_check, bound below
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module nsc_check_asserts #(
  parameter int unsigned TBL_DEPTH = 16
) (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire logic                       cmdValid,
  input wire logic [nsc_pkg::OPC_W-1:0]  cmdOpcode,
  input wire logic [nsc_pkg::NAMESPACE_ID_FIELD_W-1:0] namespaceIdField,
  input wire logic                       cmdIsIdentify,
  input wire logic                       controllerReadyFlag,
  input wire logic                       cplValid,
  input wire logic [nsc_pkg::STAT_W-1:0] cplStatus,
  input wire logic [1:0]                 cplDirection,
  input wire logic                       cplDataAllowed,
  input wire logic [4:0]                 cplClass,
  input wire logic                       listValid,
  input wire logic [nsc_pkg::NAMESPACE_ID_FIELD_W-1:0] listId
);
  import nsc_pkg::*;
  logic        take;
  logic        defOp;
  logic        plain;
  logic [1:0]  opDir;
  logic [10:0] listCnt_r;
  logic [10:0] listCnt_nxt;
  assign take  = cmdValid && controllerReadyFlag;
  assign opDir = cmdOpcode[1:0];
  assign plain = take && !cmdIsIdentify && defOp;
  always_comb begin
    case (cmdOpcode)
      OPC_FLUSH, OPC_WRITE, OPC_READ, OPC_WR_UNCOR, OPC_COMPARE, OPC_WR_ZERO,
      OPC_DSET_MGMT, OPC_VERIFY, OPC_RSV_REG, OPC_RSV_RPT, OPC_RSV_ACQ,
      OPC_RSV_REL: defOp = 1'b1;
      default:     defOp = 1'b0;
    endcase
  end
  // entries emitted since the last identify command
  always_comb begin
    listCnt_nxt = listCnt_r + {10'h000, listValid};
    if (take && cmdIsIdentify) begin
      listCnt_nxt = 11'h000;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      listCnt_r <= 11'h000;
    end else begin
      listCnt_r <= listCnt_nxt;
    end
  end
  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_cpl_answer: assert property (take |=> cplValid)
    else $error("command taken without completion");
  a_ready_refuse: assert property (cmdValid && !controllerReadyFlag |=> !cplValid)
    else $error("completion for command while not ready");
  a_dir_copy: assert property (take && !cmdIsIdentify |=> cplDirection == $past(opDir))
    else $error("direction differs from opcode low bits");
  a_rsv_opcode: assert property (
    take && !cmdIsIdentify && !defOp && !cmdOpcode[OPC_VENDOR_BIT] |=> cplStatus == ST_INV_OPCODE)
    else $error("reserved opcode not refused");
  a_bcast_reject: assert property (
    plain && cmdOpcode != OPC_FLUSH && namespaceIdField == NAMESPACE_ID_FIELD_BROADCAST
    |=> cplStatus == ST_INV_NS_FMT && cplClass == NSC_CL_BCAST)
    else $error("broadcast accepted by command");
  a_zero_invalid: assert property (
    plain && namespaceIdField == NAMESPACE_ID_FIELD_ZERO |=> cplStatus == ST_INV_NS_FMT && cplClass == NSC_CL_INVALID)
    else $error("zero identifier not invalid");
  a_inactive_field: assert property (
    plain |=> (cplStatus == ST_INV_FIELD) == (cplClass inside {NSC_CL_INACTIVE, NSC_CL_UNALLOC}))
    else $error("inactive status and class disagree");
  a_abort_nodata: assert property (cplValid && cplStatus != ST_SUCCESS |-> !cplDataAllowed)
    else $error("data allowed on aborted command");
  a_none_nodata: assert property (cplValid && cplDirection == NSC_DIR_NONE |-> !cplDataAllowed)
    else $error("data allowed without transfer direction");
  a_class_onehot: assert property (plain |=> $onehot(cplClass))
    else $error("identifier class not one-hot");
  a_list_bound: assert property (
    listValid |-> listCnt_r < LIST_MAX && listId != NAMESPACE_ID_FIELD_ZERO && listId <= TBL_DEPTH)
    else $error("list entry out of range");
  c_inv_field: cover property (cplValid && cplStatus == ST_INV_FIELD);
  c_inv_nsfmt: cover property (cplValid && cplStatus == ST_INV_NS_FMT);
  c_list_hit: cover property (listValid);
endmodule
bind nsc_check nsc_check_asserts #(.TBL_DEPTH(TBL_DEPTH)) u_nscChk (
  .clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
  .namespaceIdField(namespaceIdField), .cmdIsIdentify(cmdIsIdentify),
  .controllerReadyFlag(controllerReadyFlag), .cplValid(cplValid), .cplStatus(cplStatus),
  .cplDirection(cplDirection), .cplDataAllowed(cplDataAllowed), .cplClass(cplClass),
  .listValid(listValid), .listId(listId));

// >>> tb/nsc_host_model.sv
// nsc_host_model: host that submits commands through its queues
// assumes the bench calls put and idle from one process
`timescale 1ns/1ps
module nsc_host_model (
  input  wire logic                       clk,
  input  wire logic                       controllerReadyFlag,
  output logic                            cmdValid,
  output logic [nsc_pkg::OPC_W-1:0]       cmdOpcode,
  output logic [nsc_pkg::NAMESPACE_ID_FIELD_W-1:0]      namespaceIdField,
  output logic [3:0]                      cmdQueueId,
  output logic                            cmdIsIdentify,
  output logic [nsc_pkg::SEL_W-1:0]       identifyStructureSelector,
  output logic [nsc_pkg::NAMESPACE_ID_FIELD_W-1:0]      listStartId
);
  import nsc_pkg::*;
  logic rude;
  initial begin
    rude = 1'b0;
    cmdValid = 1'b0;
    cmdOpcode = 8'h00;
    namespaceIdField = 32'h0;
    cmdQueueId = 4'h0;
    cmdIsIdentify = 1'b0;
    identifyStructureSelector = 8'h00;
    listStartId = 32'h0;
  end
  task automatic put(input logic [7:0] op, input logic [31:0] id, input logic isId,
                     input logic [7:0] sel, input logic [31:0] start);
    int n;
    n = 0;
    while (!controllerReadyFlag && !rude && n < 8) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdOpcode <= op;
    namespaceIdField <= id;
    cmdIsIdentify <= isId;
    identifyStructureSelector <= sel;
    listStartId <= start;
    cmdQueueId <= cmdQueueId + 4'h1;
  endtask
  // released opcode, identifier, identify flag and start id are inverted; selector and queue id keep their value
  task automatic idle();
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdOpcode <= ~cmdOpcode;
    namespaceIdField <= ~namespaceIdField;
    cmdIsIdentify <= ~cmdIsIdentify;
    listStartId <= ~listStartId;
  endtask
endmodule

// >>> tb/nsc_check_test.sv
// nsc_check_test: self-checking bench for nsc_check
// assumes nsc_host_model drives the command side
`timescale 1ns/1ps
module nsc_check_test;
  import nsc_pkg::*;
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic        rdy = 1'b0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        cmdValid, cmdIsIdentify, cplValid, cplDataAllowed, cplBroadcast;
  logic        cplNsDataZero, listValid, listLast;
  logic [7:0]  cmdOpcode, identifyStructureSelector, cplStatus;
  logic [31:0] namespaceIdField, listStartId, listId, regRdata;
  logic [3:0]  cmdQueueId;
  logic [1:0]  cplDirection;
  logic [4:0]  cplClass;
  logic [31:0] got[$];
  logic [7:0]  defOps[12] = '{OPC_FLUSH, OPC_WRITE, OPC_READ, OPC_WR_UNCOR, OPC_COMPARE,
    OPC_WR_ZERO, OPC_DSET_MGMT, OPC_VERIFY, OPC_RSV_REG, OPC_RSV_RPT, OPC_RSV_ACQ, OPC_RSV_REL};
  logic [7:0]  rsvOps[3] = '{8'h03, 8'h06, 8'h7F};
  int          mismatches = 0;
  int          total_checks = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (listValid) got.push_back(listId);
  nsc_host_model HOST (.clk(clk), .controllerReadyFlag(rdy), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .namespaceIdField(namespaceIdField), .cmdQueueId(cmdQueueId),
    .cmdIsIdentify(cmdIsIdentify), .identifyStructureSelector(identifyStructureSelector),
    .listStartId(listStartId));
  nsc_check #(.TBL_DEPTH(16)) DUT (.clk(clk), .sys_rst(sysRst), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .namespaceIdField(namespaceIdField), .cmdQueueId(cmdQueueId),
    .cmdIsIdentify(cmdIsIdentify), .identifyStructureSelector(identifyStructureSelector),
    .listStartId(listStartId), .controllerReadyFlag(rdy), .sharedFeatures(1'b1),
    .cplValid(cplValid), .cplStatus(cplStatus), .cplDirection(cplDirection),
    .cplDataAllowed(cplDataAllowed), .cplBroadcast(cplBroadcast),
    .cplNsDataZero(cplNsDataZero), .cplClass(cplClass), .listValid(listValid),
    .listId(listId), .listLast(listLast), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("regRdata", regRdata & m, e);
  endtask
  task automatic ent(input logic [31:0] id, input logic [31:0] v);
    wr(REG_TBL_IDX, id - 32'd1);
    wr(REG_TBL_DATA, v);
  endtask
  task automatic sub(input logic [7:0] op, input logic [31:0] id, input logic idf,
                     input logic [7:0] sel, input logic [31:0] st);
    HOST.put(op, id, idf, sel, st);
    HOST.idle();
    #1;
  endtask
  task automatic cpl(input logic [7:0] st, input logic [4:0] cl);
    chk("cplValid", cplValid, 1);
    chk("cplStatus", cplStatus, st);
    if (cl != 5'h00) chk("cplClass", cplClass, cl);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] id, input logic [7:0] st,
                     input logic [4:0] cl);
    sub(op, id, 1'b0, 8'h00, 32'h0);
    cpl(st, cl);
  endtask
  task automatic lst(input logic [7:0] sel, input logic [31:0] st, input logic [31:0] exp[$]);
    int n;
    got.delete();
    sub(8'h06, 32'h0, 1'b1, sel, st);
    n = 0;
    while (!listLast && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("listLast", listLast, 1);
    chk("listCount", got.size(), exp.size());
    foreach (exp[i]) chk("listId", got[i], exp[i]);
  endtask
  initial begin
    #3000000;
    mismatches++;
    stop_test();
  end
  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    rdy <= 1'b1;
    rd(REG_NS_COUNT, 32'hFFFFFFFF, NS_COUNT_RST);
    rd(REG_ALLOC_CAP, 32'hFFFFFFFF, ALLOC_CAP_RST);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    ent(32'h1, 32'h3);
    ent(32'h2, 32'h1);
    ent(32'h5, 32'h3);
    ent(32'h3, 32'h2);
    rd(REG_TBL_DATA, 32'hFFFFFFFF, 32'h0);
    wr(REG_ALLOC_CAP, 32'h3);
    ent(32'h6, 32'h1);
    rd(REG_TBL_DATA, 32'hFFFFFFFF, 32'h0);
    rd(REG_STATUS, 32'hFFFF0001, 32'h00030001);
    wr(REG_ALLOC_CAP, 32'h0);
    ent(32'h6, 32'h1);
    rd(REG_TBL_DATA, 32'hFFFFFFFF, 32'h1);
    ent(32'h6, 32'h0);
    foreach (defOps[i]) begin
      cmd(defOps[i], 32'h1, ST_SUCCESS, NSC_CL_ACTIVE);
      chk("cplDirection", cplDirection, defOps[i][1:0]);
      chk("cplDataAllowed", cplDataAllowed, defOps[i][1:0] != 2'h0);
    end
    foreach (rsvOps[i]) cmd(rsvOps[i], 32'h1, ST_INV_OPCODE, 5'h00);
    cmd(8'h81, 32'h2, ST_SUCCESS, 5'h00);
    chk("cplDirection", cplDirection, 2'h1);
    cmd(OPC_READ, NAMESPACE_ID_FIELD_ZERO, ST_INV_NS_FMT, NSC_CL_INVALID);
    cmd(OPC_READ, 32'h11, ST_INV_NS_FMT, NSC_CL_INVALID);
    cmd(OPC_READ, NAMESPACE_ID_FIELD_BROADCAST, ST_INV_NS_FMT, NSC_CL_BCAST);
    cmd(OPC_FLUSH, NAMESPACE_ID_FIELD_BROADCAST, ST_SUCCESS, NSC_CL_BCAST);
    chk("cplBroadcast", cplBroadcast, 1);
    cmd(OPC_READ, 32'h2, ST_INV_FIELD, NSC_CL_INACTIVE);
    cmd(OPC_READ, 32'h10, ST_INV_FIELD, NSC_CL_UNALLOC);
    wr(REG_NS_COUNT, 32'h4);
    cmd(OPC_READ, 32'h5, ST_INV_NS_FMT, NSC_CL_INVALID);
    cmd(OPC_READ, 32'h4, ST_INV_FIELD, NSC_CL_UNALLOC);
    wr(REG_NS_COUNT, NS_COUNT_RST);
    HOST.put(OPC_WRITE, 32'h2, 1'b0, 8'h00, 32'h0);
    HOST.put(OPC_WRITE, NAMESPACE_ID_FIELD_ZERO, 1'b0, 8'h00, 32'h0);
    #1 cpl(ST_INV_FIELD, NSC_CL_INACTIVE);
    HOST.idle();
    #1 cpl(ST_INV_NS_FMT, NSC_CL_INVALID);
    sub(8'h06, 32'h1, 1'b1, SEL_NS_DATA, 32'h0);
    chk("cplNsDataZero", cplNsDataZero, 0);
    sub(8'h06, 32'h2, 1'b1, SEL_NS_DATA, 32'h0);
    chk("cplNsDataZero", cplNsDataZero, 1);
    lst(SEL_ACTIVE_LST, 32'h0, '{32'h1, 32'h5});
    lst(SEL_ACTIVE_LST, 32'h1, '{32'h5});
    lst(SEL_ALLOC_LST, 32'h0, '{32'h1, 32'h2, 32'h5});
    @(posedge clk);
    rdy <= 1'b0;
    HOST.rude = 1'b1;
    sub(OPC_READ, 32'h1, 1'b0, 8'h00, 32'h0);
    chk("cplValid", cplValid, 0);
    rd(REG_ABORTS, 32'hFFFFFFFF, 32'h0000000C);
    stop_test();
  end
endmodule
